// ===== cgr_pkg.sv
// package for the codec gain and input-select register bank
// assumes a 32-bit axi4-lite slave; one clock, synchronous reset
package cgr_pkg;
	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_GAIN = 8'h00; // shared gain register
	localparam logic [7:0] ADDR_INSEL = 8'h04; // analog input select
	localparam logic [7:0] ADDR_WALK = 8'h08; // read walk position
	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] SUB_ADC = 2'h0; // adc gain sub-register
	localparam logic [1:0] SUB_DAC = 2'h1; // dac gain sub-register
	localparam logic [1:0] SUB_SIDE = 2'h2; // sidetone and buffer
	localparam logic [1:0] SUB_VER = 2'h3; // version sub-register
	localparam logic [5:0] GAIN_RESET = 6'h2A; // 0 dB
	localparam logic [5:0] GAIN_MUTE = 6'h3F; // mute code
	localparam logic [2:0] SIDE_RESET = 3'h7; // sidetone muted
	localparam logic [2:0] SIDE_MUTE = 3'h7;
	localparam logic [1:0] BUF_RESET = 2'h0; // 0 dB buffer
	localparam logic [1:0] INSEL_RESET = 2'h0; // pair one
	localparam logic [3:0] VER_RESERVED = 4'h0; // reserved bits value
	localparam logic [1:0] VER_ID = 2'h1; // arbitrary version value
	// ------------------------------------------------------------
	// analog input choices
	// ------------------------------------------------------------
	localparam logic [1:0] AIN_PAIR_ONE = 2'h0;
	localparam logic [1:0] AIN_MIC_SELF = 2'h1;
	localparam logic [1:0] AIN_MIC_EXT = 2'h2;
	localparam logic [1:0] AIN_PAIR_TWO = 2'h3;
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic mute; // gain is muted
		logic signed [7:0] db; // gain in dB when not muted
	} cgr_gain_t;
	typedef struct packed {
		logic pair_one;
		logic mic_self;
		logic mic_ext;
		logic pair_two;
	} cgr_ain_t;
	typedef enum logic [1:0] {
		CGR_IDLE,
		CGR_BRESP,
		CGR_RRESP
	} cgr_bus_t;
endpackage

// ===== cgr_walk.sv
// read-walk pointer for the shared gain register
// assumes one read step per accepted read of that register
module cgr_walk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic step, // a shared-register read was taken
	output logic [1:0] sub // sub-register the next read returns
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] sub;
	} cgr_walk_state_t;
	cgr_walk_state_t state, next_state;
	// advance adc, dac, sidetone, version then wrap
	always_comb begin
		next_state = state;
		if (step) begin
			next_state.sub = state.sub + 2'h1;
		end
	end
	// register the walk position
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state.sub <= cgr_pkg::SUB_ADC;
		end else begin
			state <= next_state;
		end
	end
	assign sub = state.sub;
endmodule

// ===== cgr_regs.sv
// codec gain and analog input-select register bank, axi4-lite slave
// assumes a well-behaved axi4-lite master and 32-bit data
// Function
// - top bits 01 write loads dac gain
// - adc and dac gains reset to 0 dB
// - reads walk adc, dac, sidetone, version
// - dac code decodes mute, +20 to -42 dB
// - sidetone field decodes mute, -21 to -3 dB
// - buffer field selects 24, 12, 6, 0 dB
// - input select picks one of four inputs
// - top bits 00 write loads adc gain
//
// Register access over AXI4-Lite and the address map were left to the implementer.
module cgr_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [5:0] adc_gain_code,
	output logic [5:0] dac_gain_code,
	output cgr_pkg::cgr_gain_t dac_gain, // decoded dac gain
	output logic [2:0] sidetone_gain_field,
	output cgr_pkg::cgr_gain_t sidetone_gain, // decoded sidetone gain
	output logic [1:0] input_buffer_gain_field,
	output logic [4:0] input_buffer_gain_db,
	output logic [1:0] analog_input_select,
	output cgr_pkg::cgr_ain_t analog_input_onehot
);
	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// six-bit pga code: all ones mutes, else code minus 42 dB
	function automatic cgr_pkg::cgr_gain_t pga_decode(input logic [5:0] c);
		cgr_pkg::cgr_gain_t g;
		g.mute = (c == cgr_pkg::GAIN_MUTE);
		g.db = g.mute ? 8'sh00 : 8'($signed({2'h0, c}) - 8'sd42);
		return g;
	endfunction
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		cgr_pkg::cgr_bus_t bus; // bus answer phase
		logic aw_held; // write address captured
		logic w_held; // write data captured
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [5:0] adc; // adc gain code
		logic [5:0] dac; // dac gain code
		logic [2:0] side; // sidetone field
		logic [1:0] ibuf; // input buffer field
		logic [1:0] ain; // analog input select
	} cgr_state_t;
	cgr_state_t state, next_state;
	logic walk_step; // shared-register read taken
	logic [1:0] walk_sub; // sub-register for the next read
	logic wr_go; // both write halves present
	logic [7:0] wbyte; // low byte of the write
	// ------------------------------------------------------------
	// read walk pointer
	// ------------------------------------------------------------
	cgr_walk u_walk (
		.aclk(aclk),
		.aresetn(aresetn),
		.step(walk_step),
		.sub(walk_sub)
	);
	// ------------------------------------------------------------
	// handshakes
	// ------------------------------------------------------------
	// address and data accepted in either order, one held each
	assign s_axi_awready = (state.bus == cgr_pkg::CGR_IDLE) && !state.aw_held;
	assign s_axi_wready = (state.bus == cgr_pkg::CGR_IDLE) && !state.w_held;
	// reads wait while a write is half collected, keeps order simple
	assign s_axi_arready = (state.bus == cgr_pkg::CGR_IDLE)
		&& !state.aw_held && !state.w_held
		&& !s_axi_awvalid && !s_axi_wvalid;
	assign walk_step = s_axi_arvalid && s_axi_arready
		&& (s_axi_araddr == cgr_pkg::ADDR_GAIN);
	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		wr_go = 1'b0;
		wbyte = 8'h00;
		case (state.bus)
			cgr_pkg::CGR_IDLE: begin
				// capture whichever halves arrive
				if (s_axi_awvalid && s_axi_awready) begin
					next_state.aw_held = 1'b1;
					next_state.awaddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					next_state.w_held = 1'b1;
					next_state.wdata = s_axi_wdata;
					next_state.wstrb = s_axi_wstrb;
				end
				wr_go = next_state.aw_held && next_state.w_held;
				wbyte = next_state.wdata[7:0];
				if (wr_go) begin
					next_state.aw_held = 1'b0;
					next_state.w_held = 1'b0;
					next_state.bresp = 2'h0;
					next_state.bus = cgr_pkg::CGR_BRESP;
					// only the low byte lane carries a register
					if (next_state.awaddr == cgr_pkg::ADDR_GAIN) begin
						if (next_state.wstrb[0]) begin
							if (wbyte[7:6] == cgr_pkg::SUB_ADC) begin
								next_state.adc = wbyte[5:0];
							end else if (wbyte[7:6] == cgr_pkg::SUB_DAC) begin
								next_state.dac = wbyte[5:0];
							end else if (wbyte[7:6] == cgr_pkg::SUB_SIDE) begin
								next_state.side = wbyte[5:3];
								next_state.ibuf = wbyte[1:0];
							end
							// top bits 11: payload dropped
						end
					end else if (next_state.awaddr == cgr_pkg::ADDR_INSEL) begin
						if (next_state.wstrb[0]) begin
							next_state.ain = wbyte[2:1];
						end
					end else if (next_state.awaddr == cgr_pkg::ADDR_WALK) begin
						// walk position is read only: slverr
						next_state.bresp = 2'h2;
					end else begin
						next_state.bresp = 2'h3; // unmapped: decerr
					end
				end else if (s_axi_arvalid && s_axi_arready) begin
					next_state.bus = cgr_pkg::CGR_RRESP;
					next_state.rresp = 2'h0;
					next_state.rdata = 32'h0000_0000;
					if (s_axi_araddr == cgr_pkg::ADDR_GAIN) begin
						// byte selected by the walk pointer
						if (walk_sub == cgr_pkg::SUB_ADC) begin
							next_state.rdata[7:0] = {walk_sub, state.adc};
						end else if (walk_sub == cgr_pkg::SUB_DAC) begin
							next_state.rdata[7:0] = {walk_sub, state.dac};
						end else if (walk_sub == cgr_pkg::SUB_SIDE) begin
							next_state.rdata[7:0] =
								{walk_sub, state.side, 1'b0, state.ibuf};
						end else begin
							next_state.rdata[7:0] = {walk_sub,
								cgr_pkg::VER_RESERVED, cgr_pkg::VER_ID};
						end
					end else if (s_axi_araddr == cgr_pkg::ADDR_INSEL) begin
						next_state.rdata[7:0] = {5'h00, state.ain, 1'b0};
					end else if (s_axi_araddr == cgr_pkg::ADDR_WALK) begin
						next_state.rdata[1:0] = walk_sub;
					end else begin
						next_state.rresp = 2'h3; // unmapped: decerr
					end
				end
			end
			cgr_pkg::CGR_BRESP: begin
				// response holds until the master takes it
				if (s_axi_bready) begin
					next_state.bus = cgr_pkg::CGR_IDLE;
				end
			end
			cgr_pkg::CGR_RRESP: begin
				if (s_axi_rready) begin
					next_state.bus = cgr_pkg::CGR_IDLE;
				end
			end
			default: begin
				next_state.bus = cgr_pkg::CGR_IDLE;
			end
		endcase
	end
	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
			state.bus <= cgr_pkg::CGR_IDLE;
			state.adc <= cgr_pkg::GAIN_RESET;
			state.dac <= cgr_pkg::GAIN_RESET;
			state.side <= cgr_pkg::SIDE_RESET;
			state.ibuf <= cgr_pkg::BUF_RESET;
			state.ain <= cgr_pkg::INSEL_RESET;
		end else begin
			state <= next_state;
		end
	end
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_bvalid = (state.bus == cgr_pkg::CGR_BRESP);
	assign s_axi_bresp = state.bresp;
	assign s_axi_rvalid = (state.bus == cgr_pkg::CGR_RRESP);
	assign s_axi_rdata = state.rdata;
	assign s_axi_rresp = state.rresp;
	assign adc_gain_code = state.adc;
	assign dac_gain_code = state.dac;
	assign dac_gain = pga_decode(state.dac);
	assign sidetone_gain_field = state.side;
	assign input_buffer_gain_field = state.ibuf;
	assign analog_input_select = state.ain;
	// sidetone: 111 mutes, else -3 dB minus 3 dB per code step
	always_comb begin
		sidetone_gain.mute = (state.side == cgr_pkg::SIDE_MUTE);
		sidetone_gain.db = sidetone_gain.mute ? 8'sh00
			: 8'(8'sd0 - 8'sd3 - 8'sd3 * $signed({5'h00, state.side}));
	end
	// buffer gain lookup in dB
	always_comb begin
		case (state.ibuf)
			2'h3: input_buffer_gain_db = 5'd24;
			2'h2: input_buffer_gain_db = 5'd12;
			2'h1: input_buffer_gain_db = 5'd6;
			default: input_buffer_gain_db = 5'd0;
		endcase
	end
	// one-hot analog input choice
	always_comb begin
		analog_input_onehot = '0;
		case (state.ain)
			cgr_pkg::AIN_PAIR_ONE: analog_input_onehot.pair_one = 1'b1;
			cgr_pkg::AIN_MIC_SELF: analog_input_onehot.mic_self = 1'b1;
			cgr_pkg::AIN_MIC_EXT: analog_input_onehot.mic_ext = 1'b1;
			default: analog_input_onehot.pair_two = 1'b1;
		endcase
	end
endmodule

// ===== cgr_regs_assertions.sv
// concurrent checks on the codec gain register bank ports
// assumes it is bound to cgr_regs; one clock, synchronous active-low reset
module cgr_regs_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [5:0] adc_gain_code,
	input wire logic [5:0] dac_gain_code,
	input wire cgr_pkg::cgr_gain_t dac_gain,
	input wire logic [2:0] sidetone_gain_field,
	input wire cgr_pkg::cgr_gain_t sidetone_gain,
	input wire logic [1:0] input_buffer_gain_field,
	input wire logic [4:0] input_buffer_gain_db,
	input wire logic [1:0] analog_input_select,
	input wire cgr_pkg::cgr_ain_t analog_input_onehot
);
	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("no rvalid");
	// a pending answer must block every new request
	busy_refuse_a: assert property (s_axi_bvalid || s_axi_rvalid |->
		!s_axi_arready && !s_axi_awready && !s_axi_wready) else $error("busy");
	// ------------------------------------------------------------
	// gain and select decode
	// ------------------------------------------------------------
	gain_update_a: assert property ($changed(dac_gain_code) ||
		$changed(adc_gain_code) |-> $rose(s_axi_bvalid)) else $error("gain");
	dac_decode_a: assert property (
		(dac_gain.mute == (dac_gain_code == 6'h3F))
		&& (dac_gain.mute || dac_gain.db == 8'(dac_gain_code) - 8'h2A))
		else $error("dac decode");
	side_decode_a: assert property ((sidetone_gain.mute ==
		(sidetone_gain_field == 3'h7)) && (sidetone_gain.mute ||
		sidetone_gain.db == 8'hFD - 8'(sidetone_gain_field) * 8'h03))
		else $error("sidetone decode");
	buf_decode_a: assert property (input_buffer_gain_db ==
		(input_buffer_gain_field == 2'h0 ? 5'h00
		: 5'h03 << input_buffer_gain_field)) else $error("buffer decode");
	ain_decode_a: assert property (analog_input_onehot ==
		4'h8 >> analog_input_select) else $error("input select decode");
endmodule

// ===== tb_top.sv
// self-checking bench for the codec gain register bank
// assumes cgr_regs as an axi4-lite slave with the checker bound beside it
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// signals and rows
	// ------------------------------------------------------------
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot, sidetone_gain_field;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, input_buffer_gain_field;
	logic [1:0] analog_input_select;
	logic [5:0] adc_gain_code, dac_gain_code;
	logic [4:0] input_buffer_gain_db;
	cgr_pkg::cgr_gain_t dac_gain, sidetone_gain;
	cgr_pkg::cgr_ain_t analog_input_onehot;
	int n_mismatch = 0;
	int num_checks = 0;
	// write address, data, then expected adc, dac, sidetone, buffer, select
	typedef struct packed {
		logic [7:0] a, d;
		logic [5:0] adc, dac;
		logic [2:0] st;
		logic [1:0] bf, sel;
	} cgr_row_t;
	localparam cgr_row_t RST_ROW =
		'{8'h00, 8'h00, 6'h2A, 6'h2A, 3'h7, 2'h0, 2'h0};
	// last row reaches the 12 dB buffer code and a mid sidetone step
	cgr_row_t rows [12] = '{'{8'h00, 8'h45, 6'h2A, 6'h05, 3'h7, 2'h0, 2'h0},
		'{8'h00, 8'h3E, 6'h3E, 6'h05, 3'h7, 2'h0, 2'h0},
		'{8'h00, 8'h7F, 6'h3E, 6'h3F, 3'h7, 2'h0, 2'h0},
		'{8'h00, 8'hB3, 6'h3E, 6'h3F, 3'h6, 2'h3, 2'h0},
		'{8'h00, 8'hC0, 6'h3E, 6'h3F, 3'h6, 2'h3, 2'h0},
		'{8'h04, 8'h06, 6'h3E, 6'h3F, 3'h6, 2'h3, 2'h3},
		'{8'h04, 8'h02, 6'h3E, 6'h3F, 3'h6, 2'h3, 2'h1},
		'{8'h00, 8'h81, 6'h3E, 6'h3F, 3'h0, 2'h1, 2'h1},
		'{8'h04, 8'h04, 6'h3E, 6'h3F, 3'h0, 2'h1, 2'h2},
		'{8'h00, 8'h00, 6'h00, 6'h3F, 3'h0, 2'h1, 2'h2},
		'{8'h04, 8'h00, 6'h00, 6'h3F, 3'h0, 2'h1, 2'h0},
		'{8'h00, 8'h92, 6'h00, 6'h3F, 3'h2, 2'h2, 2'h0}};
	// read bytes from reset: adc, dac, sidetone, version, then wrap
	logic [31:0] walk0 [5] = '{32'h2A, 32'h6A, 32'hB8, 32'hC1, 32'h2A};
	cgr_regs dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .adc_gain_code, .dac_gain_code, .dac_gain,
		.sidetone_gain_field, .sidetone_gain, .input_buffer_gain_field,
		.input_buffer_gain_db, .analog_input_select, .analog_input_onehot);
	// ------------------------------------------------------------
	// compare, bus and closing tasks
	// ------------------------------------------------------------
	task automatic chk_val(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_resp(input logic [1:0] e, g);
		chk_val("resp", {30'h0, e}, {30'h0, g});
	endtask
	task automatic chk_outs(input cgr_row_t r);
		chk_val("outputs", 32'({r.adc, r.dac, r.st, r.bf, r.sel}),
			32'({adc_gain_code, dac_gain_code, sidetone_gain_field,
			input_buffer_gain_field, analog_input_select}));
	endtask
	// decoded gains and input choice worked out from the expected codes
	task automatic chk_dec(input cgr_row_t r);
		logic dm, sm;
		logic [7:0] ddb, sdb;
		logic [4:0] bdb;
		dm = (r.dac == 6'h3F);
		sm = (r.st == 3'h7);
		ddb = dm ? 8'h00 : 8'({2'h0, r.dac}) - 8'h2A;
		sdb = sm ? 8'h00 : 8'hFD - 8'h03 * 8'(r.st);
		bdb = (r.bf == 2'h0) ? 5'h00 : 5'h03 << r.bf;
		chk_val("dac gain", 32'({dm, ddb}), 32'(dac_gain));
		chk_val("sidetone gain", 32'({sm, sdb}), 32'(sidetone_gain));
		chk_val("buffer gain", 32'(bdb), 32'(input_buffer_gain_db));
		chk_val("input onehot", 32'(4'h8 >> r.sel), 32'(analog_input_onehot));
	endtask
	// st cycles of bready low exercise the slave holding its answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input int st, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (st == 0);
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n == st) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
		if (n >= 40) n_mismatch++;
		chk_resp(er, s_axi_bresp);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input int st,
		input logic [1:0] er, input logic [31:0] ed);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (st == 0);
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n == st) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
		if (n >= 40) n_mismatch++;
		chk_resp(er, s_axi_rresp);
		chk_val("rdata", ed, s_axi_rdata);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// far beyond the hundred or so cycles the sequence needs
	initial begin
		#20000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
		s_axi_wdata = 32'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_outs(RST_ROW);
		chk_dec(RST_ROW);
		foreach (walk0[i]) rd(8'h00, i % 3, 2'h0, walk0[i]);
		// bready held low up to two cycles makes the slave keep its answer
		foreach (rows[i]) begin
			wr(rows[i].a, {24'h0, rows[i].d}, 4'hF, i % 3, 2'h0);
			chk_outs(rows[i]);
			chk_dec(rows[i]);
		end
		// walk sits on dac after five reads; version ignores writes
		rd(8'h08, 0, 2'h0, 32'h1);
		rd(8'h00, 1, 2'h0, 32'h7F);
		rd(8'h00, 0, 2'h0, 32'h92);
		wr(8'h00, 32'hFF, 4'hF, 0, 2'h0);
		rd(8'h00, 2, 2'h0, 32'hC1);
		wr(8'h00, 32'h45, 4'h0, 0, 2'h0);
		chk_outs(rows[11]);
		chk_dec(rows[11]);
		wr(8'h08, 32'h1, 4'hF, 0, 2'h2);
		wr(8'h0C, 32'h1, 4'hF, 0, 2'h3);
		rd(8'h0C, 0, 2'h3, 32'h0);
		// second reset mid-run restores values and the walk
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_outs(RST_ROW);
		chk_dec(RST_ROW);
		rd(8'h00, 0, 2'h0, 32'h2A);
		complete_run();
	end
endmodule
bind cgr_regs cgr_regs_chk chk_u (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .adc_gain_code, .dac_gain_code, .dac_gain,
	.sidetone_gain_field, .sidetone_gain, .input_buffer_gain_field,
	.input_buffer_gain_db, .analog_input_select, .analog_input_onehot);
